// ==== common/bus_host_defs.vh ====
/*
  Constants for the request/response bus host: field widths, the atomic
  operation codes, the command register map and the response timeout.
  Included by bare name; holds definitions only.
*/
`ifndef BUS_HOST_DEFS_VH
`define BUS_HOST_DEFS_VH

`define ADDR_W          32
`define DATA_W          32
`define BEN_W           4
`define AMOOP_W         4

// Command register offsets (word indices on the Avalon-MM slave)
`define REG_ADDR        4'h0
`define REG_WDATA       4'h1
`define REG_CTRL        4'h2
`define REG_STATUS      4'h3
`define REG_RDATA       4'h4
`define REG_OOB         4'h5
`define REG_ADDR_W      4

// Control register fields; a write with GO set in lane 0 launches one transaction when idle
`define CTRL_GO         0
`define CTRL_WRITE      1
`define CTRL_ORIGIN     2
`define CTRL_PRIV       3
`define CTRL_AMO        4
`define CTRL_PORT       5
`define CTRL_BEN_LO     8
`define CTRL_AMOOP_LO   12

// Status register fields
`define STAT_BUSY       0
`define STAT_DONE       1
`define STAT_ERR        2
`define STAT_TIMEOUT    3

// Out-of-band register fields; fence bits are self-clearing
`define OOB_FENCE_D     0
`define OOB_FENCE_I     1
`define OOB_SLEEP       2
`define OOB_DEBUG       3

// Atomic operation codes
`define AMO_SWAP        4'h0
`define AMO_ADD         4'h1
`define AMO_XOR         4'h2
`define AMO_AND         4'h3
`define AMO_OR          4'h4
`define AMO_MINU        4'h6
`define AMO_MAXU        4'h7
`define AMO_MIN         4'hE
`define AMO_MAX         4'hF

// Response wait limit, in microseconds and in 100 MHz cycles
`define RSP_TIMEOUT_US  10
`define CLK_MHZ         100
`define RSP_TIMEOUT_CYC (`RSP_TIMEOUT_US * `CLK_MHZ)

`endif

// ==== design/bus_host.v ====
/*
  Host controller for the request/response bus. Software loads a command
  over Avalon-MM; the host issues it on the fetch or the load/store port,
  collects the answer and reports status. Out-of-band fence, sleep and
  debug indications are driven from a register. Assumes one 100 MHz clock
  shared with the device and a device that answers within the timeout.
*/
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "bus_host_defs.vh"

module bus_host #(
  parameter TIMEOUT_CYC = `RSP_TIMEOUT_CYC                  // Response wait limit
) (
  input  wire                 SYS_CLK,          // 100 MHz clock
  input  wire                 RSTN,             // Async reset, active low
  input  wire [3:0]           AVS_ADDRESS,      // Word index of register
  input  wire                 AVS_READ,         // Read request
  input  wire                 AVS_WRITE,        // Write request
  input  wire [31:0]          AVS_WRITEDATA,    // Write data
  input  wire [3:0]           AVS_BYTEENABLE,   // Byte lanes of write
  output reg  [31:0]          AVS_READDATA,     // Read data
  output reg                  AVS_WAITREQUEST,  // Stall
  output reg  [`ADDR_W-1:0]   I_ADDR,           // Fetch port address
  output reg  [`DATA_W-1:0]   I_WDATA,          // Fetch port write data
  output reg  [`BEN_W-1:0]    I_BEN,            // Fetch port byte lanes
  output reg                  I_STB,            // Fetch port strobe
  output reg                  I_RW,             // Fetch port direction
  output reg                  I_ACCESS_ORIGIN,  // Fetch port origin
  output reg                  I_PRIV,           // Fetch port privilege
  output reg                  I_AMO,            // Fetch port atomic flag
  output reg  [`AMOOP_W-1:0]  I_AMOOP,          // Fetch port atomic code
  input  wire [`DATA_W-1:0]   I_RSP_DATA,       // Fetch port read data
  input  wire                 I_RSP_ACK,        // Fetch port acknowledge
  input  wire                 I_RSP_ERR,        // Fetch port error
  output reg  [`ADDR_W-1:0]   D_ADDR,           // Data port address
  output reg  [`DATA_W-1:0]   D_WDATA,          // Data port write data
  output reg  [`BEN_W-1:0]    D_BEN,            // Data port byte lanes
  output reg                  D_STB,            // Data port strobe
  output reg                  D_RW,             // Data port direction
  output reg                  D_ACCESS_ORIGIN,  // Data port origin
  output reg                  D_PRIV,           // Data port privilege
  output reg                  D_AMO,            // Data port atomic flag
  output reg  [`AMOOP_W-1:0]  D_AMOOP,          // Data port atomic code
  input  wire [`DATA_W-1:0]   D_RSP_DATA,       // Data port read data
  input  wire                 D_RSP_ACK,        // Data port acknowledge
  input  wire                 D_RSP_ERR,        // Data port error
  output reg                  FENCE,            // Fence pulse
  output reg                  FENCE_I,          // Instruction fence pulse
  output reg                  SLEEP,            // All upstream asleep
  output reg                  DEBUG             // Upstream in debug mode
);

  reg  [`ADDR_W-1:0] addr_q;
  reg  [`DATA_W-1:0] wdata_q;
  reg  [31:0]        ctrl_q;
  reg  [`DATA_W-1:0] rdata_q;
  reg                done_q;
  reg                err_q;
  reg                tmo_q;
  reg                sleep_q;
  reg                debug_q;
  reg  [15:0]        wait_q;
  reg                launch_q;
  reg                port_q;

  // Port outputs from the two instances; re-registered to drive the pins
  wire [`ADDR_W-1:0]  ia, da;
  wire [`DATA_W-1:0]  iw, dw, ird, drd;
  wire [`BEN_W-1:0]   ib, db;
  wire [`AMOOP_W-1:0] io, dop;
  wire is, ir, ig, ip, im, ibz, idn, ifl;
  wire ds, dr, dg, dp, dm, dbz, ddn, dfl;

  wire busy   = ibz | dbz | launch_q;
  wire acc    = AVS_READ | AVS_WRITE;
  wire wr_hit = AVS_WRITE & ~AVS_WAITREQUEST;
  wire tmo    = (wait_q == TIMEOUT_CYC[15:0]) & (ibz | dbz);
  wire ended  = idn | ddn;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (be[k]) merge[8*k +: 8] = nw[8*k +: 8];
    end
  endfunction

  // Each access answers one cycle after it is raised: waitrequest drops then
  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h00000000;
    end else begin
      AVS_WAITREQUEST <= ~(acc & AVS_WAITREQUEST);
      AVS_READDATA    <= 32'h00000000;
      if (AVS_READ && AVS_WAITREQUEST) begin
        case (AVS_ADDRESS)
          `REG_ADDR:   AVS_READDATA <= addr_q;
          `REG_WDATA:  AVS_READDATA <= wdata_q;
          `REG_CTRL:   AVS_READDATA <= ctrl_q;
          `REG_STATUS: AVS_READDATA <= {28'h0000000, tmo_q, err_q, done_q, busy};
          `REG_RDATA:  AVS_READDATA <= rdata_q;
          `REG_OOB:    AVS_READDATA <= {28'h0000000, debug_q, sleep_q, 2'b00};
          default:     AVS_READDATA <= 32'h00000000;
        endcase
      end
    end
  end

  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      addr_q   <= 32'h00000000;
      wdata_q  <= 32'h00000000;
      ctrl_q   <= 32'h00000F00;
      rdata_q  <= 32'h00000000;
      done_q   <= 1'b0;
      err_q    <= 1'b0;
      tmo_q    <= 1'b0;
      sleep_q  <= 1'b0;
      debug_q  <= 1'b0;
      launch_q <= 1'b0;
      port_q   <= 1'b0;
      wait_q   <= 16'h0000;
      FENCE    <= 1'b0;
      FENCE_I  <= 1'b0;
    end else begin
      launch_q <= 1'b0;
      FENCE    <= 1'b0;
      FENCE_I  <= 1'b0;
      wait_q   <= (ibz | dbz) ? wait_q + 16'h0001 : 16'h0000;
      if (wr_hit) begin
        case (AVS_ADDRESS)
          `REG_ADDR:  addr_q  <= merge(addr_q, AVS_WRITEDATA, AVS_BYTEENABLE);
          `REG_WDATA: wdata_q <= merge(wdata_q, AVS_WRITEDATA, AVS_BYTEENABLE);
          `REG_CTRL: begin
            ctrl_q <= merge(ctrl_q, AVS_WRITEDATA, AVS_BYTEENABLE) & 32'h0000FF3E;
            // A launch while busy is dropped, keeping one transaction outstanding across both ports
            if (AVS_BYTEENABLE[0] && AVS_WRITEDATA[`CTRL_GO] && !busy) begin
              launch_q <= 1'b1;
              port_q   <= AVS_WRITEDATA[`CTRL_PORT];
              done_q   <= 1'b0;
              err_q    <= 1'b0;
              tmo_q    <= 1'b0;
            end
          end
          `REG_OOB: begin
            if (AVS_BYTEENABLE[0]) begin
              FENCE   <= AVS_WRITEDATA[`OOB_FENCE_D];
              FENCE_I <= AVS_WRITEDATA[`OOB_FENCE_I];
              sleep_q <= AVS_WRITEDATA[`OOB_SLEEP];
              debug_q <= AVS_WRITEDATA[`OOB_DEBUG];
            end
          end
          default: ;
        endcase
      end
      if (ended) begin
        done_q  <= 1'b1;
        err_q   <= ifl | dfl;
        rdata_q <= idn ? ird : drd;
      end else if (tmo) begin
        tmo_q  <= 1'b1;
        done_q <= 1'b1;
        err_q  <= 1'b1;
      end
    end
  end

  // Re-register the bundles so every bus signal leaves from a flip-flop
  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      I_ADDR <= 32'h00000000; I_WDATA <= 32'h00000000; I_BEN <= 4'h0;
      I_STB <= 1'b0; I_RW <= 1'b0; I_ACCESS_ORIGIN <= 1'b0; I_PRIV <= 1'b0;
      I_AMO <= 1'b0; I_AMOOP <= 4'h0;
      D_ADDR <= 32'h00000000; D_WDATA <= 32'h00000000; D_BEN <= 4'h0;
      D_STB <= 1'b0; D_RW <= 1'b0; D_ACCESS_ORIGIN <= 1'b0; D_PRIV <= 1'b0;
      D_AMO <= 1'b0; D_AMOOP <= 4'h0;
      SLEEP <= 1'b0; DEBUG <= 1'b0;
    end else begin
      I_ADDR <= ia; I_WDATA <= iw; I_BEN <= ib; I_STB <= is; I_RW <= ir;
      I_ACCESS_ORIGIN <= ig; I_PRIV <= ip; I_AMO <= im; I_AMOOP <= io;
      D_ADDR <= da; D_WDATA <= dw; D_BEN <= db; D_STB <= ds; D_RW <= dr;
      D_ACCESS_ORIGIN <= dg; D_PRIV <= dp; D_AMO <= dm; D_AMOOP <= dop;
      SLEEP <= sleep_q;
      DEBUG <= debug_q;
    end
  end

  // The pin stage delays the strobe one cycle; the port's own guard covers only its strobe cycle,
  // so i_pend_q and d_pend_q mask any response in the pin strobe cycle.
  reg i_pend_q, d_pend_q;
  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      i_pend_q <= 1'b0;
      d_pend_q <= 1'b0;
    end else begin
      i_pend_q <= is;
      d_pend_q <= ds;
    end
  end

  req_port u_iport (
    .clk(SYS_CLK), .rst_n(RSTN),
    .start(launch_q & ~port_q),
    .addr_in(addr_q), .wdata_in(wdata_q), .ben_in(ctrl_q[`CTRL_BEN_LO +: 4]),
    .write_in(ctrl_q[`CTRL_WRITE]), .origin_in(ctrl_q[`CTRL_ORIGIN]),
    .priv_in(ctrl_q[`CTRL_PRIV]), .amo_in(ctrl_q[`CTRL_AMO]),
    .amoop_in(ctrl_q[`CTRL_AMOOP_LO +: 4]), .abort(tmo),
    .rsp_data(I_RSP_DATA), .rsp_ack(I_RSP_ACK & ~i_pend_q),
    .rsp_err(I_RSP_ERR & ~i_pend_q),
    .addr_q(ia), .wdata_q(iw), .ben_q(ib), .stb_q(is), .rw_q(ir),
    .origin_q(ig), .priv_q(ip), .amo_q(im), .amoop_q(io), .busy_q(ibz),
    .done(idn), .failed(ifl), .rdata(ird)
  );

  req_port u_dport (
    .clk(SYS_CLK), .rst_n(RSTN),
    .start(launch_q & port_q),
    .addr_in(addr_q), .wdata_in(wdata_q), .ben_in(ctrl_q[`CTRL_BEN_LO +: 4]),
    .write_in(ctrl_q[`CTRL_WRITE]), .origin_in(ctrl_q[`CTRL_ORIGIN]),
    .priv_in(ctrl_q[`CTRL_PRIV]), .amo_in(ctrl_q[`CTRL_AMO]),
    .amoop_in(ctrl_q[`CTRL_AMOOP_LO +: 4]), .abort(tmo),
    .rsp_data(D_RSP_DATA), .rsp_ack(D_RSP_ACK & ~d_pend_q),
    .rsp_err(D_RSP_ERR & ~d_pend_q),
    .addr_q(da), .wdata_q(dw), .ben_q(db), .stb_q(ds), .rw_q(dr),
    .origin_q(dg), .priv_q(dp), .amo_q(dm), .amoop_q(dop), .busy_q(dbz),
    .done(ddn), .failed(dfl), .rdata(drd)
  );

endmodule // bus_host

`default_nettype wire

// ==== design/req_port.v ====
/*
  One request port of the host: registers the request bundle, launches a
  one-cycle strobe, holds the fields until ack or err, and reports the end.
  Assumes the response arrives on the same clock, registered by the device.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bus_host_defs.vh"

module req_port (
  input  wire                  clk,        // System clock
  input  wire                  rst_n,      // Async reset, active low
  input  wire                  start,      // Launch one transaction
  input  wire [`ADDR_W-1:0]    addr_in,    // Address for launch
  input  wire [`DATA_W-1:0]    wdata_in,   // Write data or atomic operand
  input  wire [`BEN_W-1:0]     ben_in,     // Byte lanes
  input  wire                  write_in,   // Direction
  input  wire                  origin_in,  // Fetch or load/store
  input  wire                  priv_in,    // Machine mode
  input  wire                  amo_in,     // Atomic
  input  wire [`AMOOP_W-1:0]   amoop_in,   // Atomic code
  input  wire                  abort,      // Timeout: drop the transaction
  input  wire [`DATA_W-1:0]    rsp_data,   // Read data from device
  input  wire                  rsp_ack,    // Success pulse
  input  wire                  rsp_err,    // Failure pulse
  output reg  [`ADDR_W-1:0]    addr_q,     // Request address
  output reg  [`DATA_W-1:0]    wdata_q,    // Request write data
  output reg  [`BEN_W-1:0]     ben_q,      // Request byte lanes
  output reg                   stb_q,      // Strobe
  output reg                   rw_q,       // Direction
  output reg                   origin_q,   // Access origin
  output reg                   priv_q,     // Privilege
  output reg                   amo_q,      // Atomic flag
  output reg  [`AMOOP_W-1:0]   amoop_q,    // Atomic code
  output reg                   busy_q,     // Transaction outstanding
  output wire                  done,       // Ended this cycle
  output wire                  failed,     // Ended by err
  output wire [`DATA_W-1:0]    rdata       // Read data at ack
);

  // Ignore a response in the strobe cycle itself: the earliest legal one is
  // the cycle after it, and no response may belong to a prior transaction.
  wire rsp_ok = busy_q & ~stb_q;

  assign done   = rsp_ok & (rsp_ack | rsp_err);
  assign failed = rsp_ok & rsp_err;
  assign rdata  = rsp_data;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q   <= {`ADDR_W{1'b0}};
      wdata_q  <= {`DATA_W{1'b0}};
      ben_q    <= {`BEN_W{1'b0}};
      stb_q    <= 1'b0;
      rw_q     <= 1'b0;
      origin_q <= 1'b0;
      priv_q   <= 1'b0;
      amo_q    <= 1'b0;
      amoop_q  <= {`AMOOP_W{1'b0}};
      busy_q   <= 1'b0;
    end else begin
      stb_q <= 1'b0;
      if (start && !busy_q) begin
        stb_q    <= 1'b1;
        busy_q   <= 1'b1;
        addr_q   <= addr_in;
        ben_q    <= ben_in;
        rw_q     <= write_in & ~amo_in;
        origin_q <= origin_in;
        priv_q   <= priv_in;
        amo_q    <= amo_in;
        amoop_q  <= amoop_in;
        wdata_q  <= (write_in | amo_in) ? wdata_in : {`DATA_W{1'b0}};
      end else if (done || abort) begin
        busy_q <= 1'b0;
      end
    end
  end

endmodule // req_port

`default_nettype wire

// ==== test/bus_host_properties.sv ====
/*
  Concurrent checks on the request/response host, bound to bus_host.
  Assumes one clock and the asynchronous active-low reset of the host.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bus_host_defs.vh"

module bus_host_props #(
  parameter int TIMEOUT_CYC = 1000  // Response wait limit
) (
  input wire logic        SYS_CLK,          // Clock
  input wire logic        RSTN,             // Reset, active low
  input wire logic [3:0]  AVS_ADDRESS,      // Register index
  input wire logic        AVS_WRITE,        // Write request
  input wire logic [31:0] AVS_WRITEDATA,    // Write data
  input wire logic [3:0]  AVS_BYTEENABLE,   // Byte lanes
  input wire logic        AVS_WAITREQUEST,  // Stall
  input wire logic [31:0] I_ADDR,           // Fetch address
  input wire logic [31:0] I_WDATA,          // Fetch write data
  input wire logic [3:0]  I_BEN,            // Fetch lanes
  input wire logic        I_STB,            // Fetch strobe
  input wire logic        I_RW,             // Fetch direction
  input wire logic        I_ACCESS_ORIGIN,  // Fetch origin
  input wire logic        I_PRIV,           // Fetch privilege
  input wire logic        I_AMO,            // Fetch atomic flag
  input wire logic [3:0]  I_AMOOP,          // Fetch atomic code
  input wire logic        I_RSP_ACK,        // Fetch acknowledge
  input wire logic        I_RSP_ERR,        // Fetch error
  input wire logic [31:0] D_ADDR,           // Data address
  input wire logic [31:0] D_WDATA,          // Data write data
  input wire logic [3:0]  D_BEN,            // Data lanes
  input wire logic        D_STB,            // Data strobe
  input wire logic        D_RW,             // Data direction
  input wire logic        D_ACCESS_ORIGIN,  // Data origin
  input wire logic        D_PRIV,           // Data privilege
  input wire logic        D_AMO,            // Data atomic flag
  input wire logic [3:0]  D_AMOOP,          // Data atomic code
  input wire logic        D_RSP_ACK,        // Data acknowledge
  input wire logic        D_RSP_ERR,        // Data error
  input wire logic        FENCE,            // Fence pulse
  input wire logic        FENCE_I           // Instruction fence pulse
);
  logic        open_q;
  logic        dport_q;
  int          cnt_q;
  wire  [75:0] i_req = {I_ADDR, I_WDATA, I_BEN, I_RW, I_ACCESS_ORIGIN, I_PRIV, I_AMO, I_AMOOP};
  wire  [75:0] d_req = {D_ADDR, D_WDATA, D_BEN, D_RW, D_ACCESS_ORIGIN, D_PRIV, D_AMO, D_AMOOP};
  wire         ended = dport_q ? (D_RSP_ACK | D_RSP_ERR) : (I_RSP_ACK | I_RSP_ERR);

  // Closed a little before the host's own limit, so an abort never trips the hold checks
  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      open_q  <= 1'b0;
      dport_q <= 1'b0;
      cnt_q   <= 0;
    end else if (I_STB | D_STB) begin
      open_q  <= 1'b1;
      dport_q <= D_STB;
      cnt_q   <= 0;
    end else if (open_q) begin
      open_q  <= !(ended || cnt_q >= TIMEOUT_CYC - 4);
      cnt_q   <= cnt_q + 1;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  sequence s_go;
    AVS_WRITE && AVS_WAITREQUEST && AVS_ADDRESS == `REG_CTRL && AVS_WRITEDATA[`CTRL_GO]
      && AVS_BYTEENABLE[0] && !open_q;
  endsequence
  sequence s_d_launch;
    s_go ##0 AVS_WRITEDATA[`CTRL_PORT];
  endsequence
  sequence s_i_launch;
    s_go ##0 !AVS_WRITEDATA[`CTRL_PORT];
  endsequence

  property p_istb_pulse; I_STB |=> !I_STB; endproperty
  property p_dstb_pulse; D_STB |=> !D_STB; endproperty
  property p_fence_pulse; FENCE |=> !FENCE; endproperty
  property p_fencei_pulse; FENCE_I |=> !FENCE_I; endproperty
  property p_one_port; !(I_STB && D_STB); endproperty
  property p_one_out; open_q |-> !(I_STB || D_STB); endproperty
  property p_d_hold; open_q && dport_q |-> $stable(d_req); endproperty
  property p_i_hold; open_q && !dport_q |-> $stable(i_req); endproperty
  property p_amo_read; D_STB && D_AMO |-> !D_RW; endproperty
  property p_go_d; s_d_launch |-> ##[1:4] D_STB; endproperty
  property p_go_i; s_i_launch |-> ##[1:4] I_STB; endproperty

  a_istb_pulse: assert property (p_istb_pulse) else $error("fetch strobe longer than one cycle");
  a_dstb_pulse: assert property (p_dstb_pulse) else $error("data strobe longer than one cycle");
  a_fence_pulse: assert property (p_fence_pulse) else $error("fence longer than one cycle");
  a_fencei_pulse: assert property (p_fencei_pulse) else $error("fence_i not single cycle");
  a_one_port: assert property (p_one_port) else $error("both ports strobed together");
  a_one_out: assert property (p_one_out) else $error("strobe while transaction open");
  a_d_hold: assert property (p_d_hold) else $error("data request fields moved");
  a_i_hold: assert property (p_i_hold) else $error("fetch request fields moved");
  a_amo_read: assert property (p_amo_read) else $error("atomic issued as write");
  a_go_d: assert property (p_go_d) else $error("no data strobe after launch");
  a_go_i: assert property (p_go_i) else $error("no fetch strobe after launch");
endmodule // bus_host_props

bind bus_host bus_host_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_props (
  .SYS_CLK, .RSTN, .AVS_ADDRESS, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_WAITREQUEST,
  .I_ADDR, .I_WDATA, .I_BEN, .I_STB, .I_RW, .I_ACCESS_ORIGIN, .I_PRIV, .I_AMO, .I_AMOOP,
  .I_RSP_ACK, .I_RSP_ERR, .D_ADDR, .D_WDATA, .D_BEN, .D_STB, .D_RW, .D_ACCESS_ORIGIN,
  .D_PRIV, .D_AMO, .D_AMOOP, .D_RSP_ACK, .D_RSP_ERR, .FENCE, .FENCE_I);

`default_nettype wire

// ==== test/bus_host_tb.sv ====
/*
  Self-checking bench for bus_host: table of ordinary transactions, every
  atomic code, then timeout, refused launch, fences and levels.
  Assumes dev_model on both ports and a shortened response limit.
*/
`timescale 1ns/1ps
`default_nettype none

module bus_host_tb;
  localparam int TO = 20;
  logic        SYS_CLK = 0, RSTN = 0, AVS_READ = 0, AVS_WRITE = 0, AVS_WAITREQUEST;
  logic [3:0]  AVS_ADDRESS = 0, AVS_BYTEENABLE = 4'hF, I_BEN, D_BEN, I_AMOOP, D_AMOOP;
  logic [31:0] AVS_WRITEDATA = 0, AVS_READDATA, I_ADDR, I_WDATA, D_ADDR, D_WDATA;
  logic [31:0] I_RSP_DATA, D_RSP_DATA, rdv = 0, s;
  logic        I_STB, I_RW, I_ACCESS_ORIGIN, I_PRIV, I_AMO, I_RSP_ACK, I_RSP_ERR;
  logic        D_STB, D_RW, D_ACCESS_ORIGIN, D_PRIV, D_AMO, D_RSP_ACK, D_RSP_ERR;
  logic        FENCE, FENCE_I, SLEEP, DEBUG, fl = 0, mute = 0;
  logic [7:0]  dly = 0;
  int          n_mismatch = 0, num_checks = 0, cyc = 0, n_stb = 0, c;
  typedef struct {logic p, w, o, v; logic [3:0] b; logic [31:0] a, d; logic [7:0] dl; logic f;} row_t;
  row_t rows[5] = '{'{0, 0, 0, 1, 4'hF, 32'h0000_0100, 32'h0, 0, 0},
                    '{1, 1, 1, 0, 4'h3, 32'hFFFF_FFFC, 32'hA5C3_0F1E, 0, 0},
                    '{1, 0, 1, 1, 4'hC, 32'h8000_0004, 32'h0, 5, 0},
                    '{1, 0, 1, 0, 4'hF, 32'h1234_5678, 32'h0, 3, 1},
                    '{0, 1, 0, 1, 4'h1, 32'h0000_0008, 32'h7777_0001, 0, 1}};
  logic [3:0]  ops[9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'hE, 4'hF};

  always #5 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) n_stb <= n_stb + (I_STB === 1'b1) + (D_STB === 1'b1);

  bus_host #(.TIMEOUT_CYC(TO)) u_dut (.SYS_CLK, .RSTN, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .I_ADDR, .I_WDATA, .I_BEN,
    .I_STB, .I_RW, .I_ACCESS_ORIGIN, .I_PRIV, .I_AMO, .I_AMOOP, .I_RSP_DATA, .I_RSP_ACK,
    .I_RSP_ERR, .D_ADDR, .D_WDATA, .D_BEN, .D_STB, .D_RW, .D_ACCESS_ORIGIN, .D_PRIV, .D_AMO,
    .D_AMOOP, .D_RSP_DATA, .D_RSP_ACK, .D_RSP_ERR, .FENCE, .FENCE_I, .SLEEP, .DEBUG);
  dev_model u_imem (.clk(SYS_CLK), .rst_n(RSTN), .stb(I_STB), .rw(I_RW), .delay(dly), .fail(fl),
    .silent(mute), .rdval(rdv), .rsp_data(I_RSP_DATA), .rsp_ack(I_RSP_ACK), .rsp_err(I_RSP_ERR));
  dev_model u_dmem (.clk(SYS_CLK), .rst_n(RSTN), .stb(D_STB), .rw(D_RW), .delay(dly), .fail(fl),
    .silent(mute), .rdval(rdv), .rsp_data(D_RSP_DATA), .rsp_ack(D_RSP_ACK), .rsp_err(D_RSP_ERR));

  task chk(input string n, input logic [95:0] e, input logic [95:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // Request held until the edge that samples waitrequest low
  task av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge SYS_CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    if (wr) AVS_WRITE <= 1'b1;
    else AVS_READ <= 1'b1;
    // No cycle limit here: a stalled slave is caught by the bench ceiling
    do @(posedge SYS_CLK);
    while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask

  task wait_done;
    int k;
    k = 0;
    do begin
      av(0, 4'h3, 0, s);
      k++;
    end while (s[1] !== 1'b1 && k < 60);
  endtask

  task go(input logic p, w, o, v, m, input logic [3:0] op, b, input logic [31:0] a, d,
          input logic [7:0] dl, input logic f, t);
    int k;
    dly <= dl;
    fl <= f;
    mute <= t;
    rdv <= a ^ 32'h5A5A_C3C3;
    av(1, 4'h0, a, s);
    av(1, 4'h1, d, s);
    av(1, 4'h2, {16'h0, op, b, 2'b00, p, m, v, o, w, 1'b1}, s);
    k = 0;
    while (!(I_STB === 1'b1 || D_STB === 1'b1) && k < 20) begin
      @(posedge SYS_CLK);
      k++;
    end
    chk("request", {a, (w | m) ? d : 32'h0, b, w & !m, o, v, m, op}, p ? {D_ADDR, D_WDATA, D_BEN,
      D_RW, D_ACCESS_ORIGIN, D_PRIV, D_AMO, D_AMOOP} : {I_ADDR, I_WDATA, I_BEN, I_RW,
      I_ACCESS_ORIGIN, I_PRIV, I_AMO, I_AMOOP});
    chk("port", p, D_STB);
    if (t) av(1, 4'h2, 32'h0000_0F01, s);
    wait_done;
    chk("status", {t, f | t, 2'b10}, s[3:0]);
    if (!(w & !m) && !f && !t) begin
      av(0, 4'h4, 0, s);
      chk("rdata", a ^ 32'h5A5A_C3C3, s);
    end
  endtask

  task summarize;
    if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Ceiling well above the several hundred cycles the sequence needs
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize;
    end
  end

  initial begin
    repeat (20) @(posedge SYS_CLK);
    chk("reset", {1'b1, 6'h0}, {AVS_WAITREQUEST, I_STB, D_STB, FENCE, FENCE_I, SLEEP, DEBUG});
    RSTN <= 1'b1;
    av(0, 4'h2, 0, s);
    chk("ctrl_rst", 32'h0000_0F00, s);
    foreach (rows[i])
      go(rows[i].p, rows[i].w, rows[i].o, rows[i].v, 0, 0, rows[i].b, rows[i].a, rows[i].d,
         rows[i].dl, rows[i].f, 0);
    foreach (ops[i])
      go(1, i % 2, 1, 1, 1, ops[i], 4'hF, 32'h40 + 4 * i, 32'hF000_0000 + i, i, 0, 0);
    c = n_stb;
    go(1, 0, 1, 0, 0, 0, 4'hF, 32'h0000_0200, 0, 0, 0, 1);
    chk("one_strobe", c + 1, n_stb);
    go(0, 0, 0, 0, 0, 0, 4'hF, 32'h0000_0300, 0, 1, 0, 0);
    av(0, 4'hF, 0, s);
    chk("unmapped", 0, s);
    // Partial lanes merge into the address register, which reads back
    AVS_BYTEENABLE <= 4'h3;
    av(1, 4'h0, 32'hFFFF_FFFF, s);
    AVS_BYTEENABLE <= 4'hF;
    av(0, 4'h0, 0, s);
    chk("addr_merge", 32'h0000_FFFF, s);
    for (int b = 0; b < 2; b++) begin
      av(1, 4'h5, 32'h1 << b, s);
      c = 0;
      repeat (8) begin
        @(posedge SYS_CLK);
        c += ((b ? FENCE_I : FENCE) === 1'b1);
      end
      chk("fence", 1, c);
    end
    av(1, 4'h5, 32'hC, s);
    repeat (3) @(posedge SYS_CLK);
    chk("levels", 2'b11, {SLEEP, DEBUG});
    av(0, 4'h5, 0, s);
    chk("oob", 32'h0000_000C, s);
    av(1, 4'h5, 32'h0, s);
    repeat (3) @(posedge SYS_CLK);
    chk("levels", 2'b00, {SLEEP, DEBUG});
    summarize;
  end
endmodule // bus_host_tb

`default_nettype wire

// ==== test/dev_model.sv ====
/*
  Behavioural memory on one request port: answers after a set delay with
  an acknowledge or an error pulse, or stays silent. Assumes the bench sets
  the delay, outcome and read value before the strobe.
*/
`timescale 1ns/1ps
`default_nettype none

module dev_model (
  input  wire logic        clk,       // Clock
  input  wire logic        rst_n,     // Reset, active low
  input  wire logic        stb,       // Request strobe
  input  wire logic        rw,        // Direction at strobe
  input  wire logic [7:0]  delay,     // Extra cycles before answer
  input  wire logic        fail,      // Answer with error
  input  wire logic        silent,    // Never answer
  input  wire logic [31:0] rdval,     // Value returned on read
  output logic      [31:0] rsp_data,  // Read data
  output logic             rsp_ack,   // Success pulse
  output logic             rsp_err    // Failure pulse
);
  logic       pend_q;
  logic       wr_q;
  logic [7:0] cnt_q;
  // Direction is taken only at the strobe; later field values are not relied on
  wire        is_wr = stb ? rw : wr_q;
  wire        fire  = !silent && (stb ? delay == 8'h00 : (pend_q && cnt_q == 8'h00));

  // All response outputs are registered
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_ack  <= 1'b0;
      rsp_err  <= 1'b0;
      rsp_data <= 32'h0;
      pend_q   <= 1'b0;
      wr_q     <= 1'b0;
      cnt_q    <= 8'h00;
    end else begin
      rsp_ack  <= fire && !fail;
      rsp_err  <= fire && fail;
      rsp_data <= (fire && !fail && !is_wr) ? rdval : 32'h0;
      if (stb) begin
        pend_q <= !silent && delay != 8'h00;
        cnt_q  <= delay - 8'h01;
        wr_q   <= rw;
      end else if (pend_q) begin
        pend_q <= cnt_q != 8'h00;
        cnt_q  <= cnt_q - 8'h01;
      end
    end
  end
endmodule // dev_model

`default_nettype wire
